// ===== frs_top.sv
// rate select register, density pin and result status bytes with APB access
//
// Decided for this implementation: the APB interface to the registers.
`include "frs_cfg.svh"
`default_nettype none
module frs_top
	import frs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command engine
	input wire logic swReset,
	input wire logic execStart,
	input wire frs_cmd_e cmdKind,
	input wire logic execEnd,
	input wire logic [1:0] completionCode,
	input wire logic headIn,
	input wire logic [1:0] unitSelect,
	// drive side events
	input wire frs_media_s media,
	// drive side outputs
	output logic [1:0] ratePick,
	output logic densityOut,
	output logic resultPhase
);
	frs_phase_e phase;
	frs_phase_e next_phase;
	frs_cmd_e curCmd;
	frs_status_s flags;
	frs_status_s next_flags;
	frs_status_s latched;
	logic [1:0] interfaceMode;
	logic skipWriteShiftFlag;
	logic byteIdx;
	logic [6:0] stepCount;
	logic [1:0] idxCount;
	logic idxPrev;
	logic tcSeen;
	logic [7:0] resByte0;
	logic [7:0] resByte1;
	logic setupPh;
	logic accessPh;
	logic wrDone;
	logic rdDone;
	logic hitCcr;
	logic hitMode;
	logic hitData;
	logic mapped;
	logic execActive;
	logic idxEdge;
	logic endNow;
	logic lastRead;
	logic clrAll;
	logic clrPos;
	logic [7:0] inputView;
	logic highRate;
	logic [31:0] next_prdata;

	// apb decode
	assign setupPh = psel && !penable;
	assign accessPh = psel && penable;
	assign pready = 1'b1;
	assign wrDone = accessPh && pwrite;
	assign rdDone = accessPh && !pwrite;
	assign hitCcr = paddr == `FRS_CCR_ADDR;
	assign hitMode = paddr == `FRS_MODE_ADDR;
	assign hitData = paddr == `FRS_DATA_ADDR;
	assign mapped = hitCcr || hitMode || hitData ||
		paddr == `FRS_RES0_ADDR || paddr == `FRS_RES1_ADDR ||
		paddr == `FRS_PHASE_ADDR;

	// phase helpers
	assign execActive = phase == FRS_PH_EXEC;
	assign endNow = execActive && execEnd;
	assign lastRead = rdDone && hitData && phase == FRS_PH_RESULT && byteIdx;
	assign resultPhase = phase == FRS_PH_RESULT;
	assign idxEdge = idxPrev && !media.revolutionPulseInN;
	assign highRate = ratePick == `FRS_RATE_500K || ratePick == `FRS_RATE_1M;

	// interface mode field
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			interfaceMode <= `FRS_MODE_RST;
		end else if (wrDone && hitMode) begin
			interfaceMode <= pwdata[`FRS_MODE_MSB:`FRS_MODE_LSB];
		end
	end

	// rate select, hardware reset only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ratePick <= `FRS_RATE_RST;
		end else if (wrDone && hitCcr) begin
			ratePick <= pwdata[1:0];
		end
	end

	// skip flag, third mode only, kept over software reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			skipWriteShiftFlag <= `FRS_SKIP_WRITE_SHIFT_FLAG_RST;
		end else if (wrDone && hitCcr && interfaceMode == FRS_MODE_M30) begin
			skipWriteShiftFlag <= pwdata[`FRS_SKIP_WRITE_SHIFT_FLAG_BIT];
		end
	end

	// density pin follows rate and mode polarity
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			densityOut <= `FRS_DENS_RST;
		end else if (wrDone && hitCcr) begin
			if (interfaceMode == FRS_MODE_AT) begin
				densityOut <= pwdata[1:0] == `FRS_RATE_500K || pwdata[1:0] == `FRS_RATE_1M;
			end else begin
				densityOut <= !(pwdata[1:0] == `FRS_RATE_500K ||
					pwdata[1:0] == `FRS_RATE_1M);
			end
		end
	end

	// input view at the config control address
	always_comb begin
		case (interfaceMode)
			FRS_MODE_PS2: begin
				inputView = {1'b0, 4'hF, ratePick, !highRate};
			end
			FRS_MODE_M30: begin
				inputView = {5'h00, skipWriteShiftFlag, ratePick};
			end
			default: begin
				inputView = 8'h00;
			end
		endcase
	end

	// phase machine
	always_comb begin
		next_phase = phase;
		case (phase)
			FRS_PH_IDLE: begin
				if (execStart) begin
					next_phase = FRS_PH_EXEC;
				end
			end
			FRS_PH_EXEC: begin
				if (execEnd) begin
					if (frs_is_position(curCmd)) begin
						next_phase = FRS_PH_IDLE;
					end else begin
						next_phase = FRS_PH_RESULT;
					end
				end
			end
			FRS_PH_RESULT: begin
				if (lastRead) begin
					next_phase = FRS_PH_IDLE;
				end
			end
			default: begin
				next_phase = FRS_PH_IDLE;
			end
		endcase
		if (swReset) begin
			next_phase = FRS_PH_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phase <= FRS_PH_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	// command in execution
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			curCmd <= FRS_CMD_NONE;
		end else if (phase == FRS_PH_IDLE && execStart && !swReset) begin
			curCmd <= cmdKind;
		end
	end

	// result byte pointer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			byteIdx <= 1'b0;
		end else if (swReset || endNow) begin
			byteIdx <= 1'b0;
		end else if (rdDone && hitData && phase == FRS_PH_RESULT) begin
			byteIdx <= !byteIdx;
		end
	end

	// recalibrate step counter
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stepCount <= 7'd0;
		end else if (phase == FRS_PH_IDLE || swReset) begin
			stepCount <= 7'd0;
		end else if (execActive && curCmd == FRS_CMD_RECAL && media.stepPulse &&
			stepCount != `FRS_RECAL_STEPS) begin
			stepCount <= stepCount + 7'd1;
		end
	end

	// index pulse counter, restarted by a found ID mark
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			idxPrev <= 1'b1;
		end else begin
			idxPrev <= media.revolutionPulseInN;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			idxCount <= 2'd0;
		end else if (phase == FRS_PH_IDLE || swReset || media.idMarkFound) begin
			idxCount <= 2'd0;
		end else if (execActive && idxEdge && idxCount != `FRS_IDX_LIMIT) begin
			idxCount <= idxCount + 2'd1;
		end
	end

	// terminal count seen during execution
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tcSeen <= 1'b0;
		end else if (phase == FRS_PH_IDLE || swReset) begin
			tcSeen <= 1'b0;
		end else if (execActive && media.terminalCountIn) begin
			tcSeen <= 1'b1;
		end
	end

	// sticky event flags, a set wins over a clear
	assign clrAll = swReset || (phase == FRS_PH_IDLE && execStart);
	assign clrPos = swReset || (endNow && curCmd == FRS_CMD_SENSE_INT) ||
		(phase == FRS_PH_IDLE && execStart && cmdKind != FRS_CMD_SENSE_INT &&
		!frs_is_position(cmdKind) ? 1'b0 : 1'b0);

	always_comb begin
		next_flags = flags;
		if (clrAll) begin
			next_flags.endOfTrack = 1'b0;
			next_flags.crcFault = 1'b0;
			next_flags.overrun = 1'b0;
			next_flags.sectorMissing = 1'b0;
			next_flags.writeProtectViolation = 1'b0;
			next_flags.syncFieldAbsent = 1'b0;
		end
		if (clrPos || (phase == FRS_PH_IDLE && execStart && frs_is_position(cmdKind))) begin
			next_flags.positioningComplete = 1'b0;
			next_flags.equipmentFault = 1'b0;
		end
		if (execActive) begin
			if (execEnd && frs_is_position(curCmd)) begin
				next_flags.positioningComplete = 1'b1;
			end
			if (curCmd == FRS_CMD_RECAL && stepCount == `FRS_RECAL_STEPS &&
				!media.trackZeroIn) begin
				next_flags.equipmentFault = 1'b1;
			end
			if (curCmd == FRS_CMD_REL_SEEK && media.stepPulse && media.stepOutward &&
				media.trackZeroIn) begin
				next_flags.equipmentFault = 1'b1;
			end
			if (media.sectorBeyondEnd) begin
				next_flags.endOfTrack = 1'b1;
			end
			if (execEnd && frs_is_data(curCmd) && !tcSeen && !media.terminalCountIn) begin
				next_flags.endOfTrack = 1'b1;
			end
			if (media.idCrcFault || media.dataCrcFault) begin
				next_flags.crcFault = 1'b1;
			end
			if (media.serviceLate) begin
				next_flags.overrun = 1'b1;
			end
			if ((media.sectorNotFound &&
				(curCmd == FRS_CMD_READ || curCmd == FRS_CMD_READ_DEL)) ||
				(media.idReadFail && curCmd == FRS_CMD_READ_ID) ||
				(media.badSequence && curCmd == FRS_CMD_READ_TRACK)) begin
				next_flags.sectorMissing = 1'b1;
			end
			if (media.writeProtectIn && frs_is_write(curCmd)) begin
				next_flags.writeProtectViolation = 1'b1;
			end
			if ((idxEdge && idxCount == `FRS_IDX_LIMIT - 2'd1 && !media.idMarkFound) ||
				media.dataMarkMissing) begin
				next_flags.syncFieldAbsent = 1'b1;
			end
		end
		next_flags.completionCode = completionCode;
		next_flags.head = headIn;
		next_flags.unitSelect = unitSelect;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flags <= '0;
		end else begin
			flags <= next_flags;
		end
	end

	// capture at execution end, held through the result phase
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			latched <= '0;
		end else if (swReset) begin
			latched <= '0;
		end else if (endNow && !frs_is_position(curCmd)) begin
			latched <= next_flags;
			if (curCmd == FRS_CMD_SENSE_INT) begin
				// sense end clears the live copy, so report the held one
				latched.positioningComplete <= flags.positioningComplete;
				latched.equipmentFault <= flags.equipmentFault;
			end else begin
				latched.positioningComplete <= 1'b0;
				latched.equipmentFault <= 1'b0;
			end
		end
	end

	frs_status_pack u_pack (
		.status(latched),
		.byte0(resByte0),
		.byte1(resByte1)
	);

	// read data mux
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hitCcr) begin
			next_prdata = {24'h00_0000, inputView};
		end else if (hitMode) begin
			next_prdata = {28'h000_0000, interfaceMode, 2'b00};
		end else if (paddr == `FRS_RES0_ADDR) begin
			next_prdata = {24'h00_0000, resByte0};
		end else if (paddr == `FRS_RES1_ADDR) begin
			next_prdata = {24'h00_0000, resByte1};
		end else if (hitData && phase == FRS_PH_RESULT) begin
			next_prdata = {24'h00_0000, byteIdx ? resByte1 : resByte0};
		end else if (paddr == `FRS_PHASE_ADDR) begin
			next_prdata = {29'h0000_0000, byteIdx, execActive, resultPhase};
		end
	end

	// read data and error are registered in the setup cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (setupPh && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pslverr <= 1'b0;
		end else if (setupPh) begin
			pslverr <= !mapped;
		end
	end
endmodule : frs_top
`default_nettype wire

// ===== frs_cfg.svh
// offsets, field positions, reset values and limits of the rate and result status block
// Function
// - write-only config control at index 3F7; low two bits pick rate; reset 10.
// - third mode: bit 2 stores skip flag, no effect, read back on bit 2.
// - skip flag survives software reset; third mode host writes zeros to bits 7..3.
// - density output high after hardware reset, untouched by software resets.
// - result phase presents status bytes of the last command through data port.
// - byte0 bits 7..6: 00 normal, 01 abnormal, 10 invalid, 11 polling.
// - byte0 bit 5 set on seek, relative seek, recalibrate end; shown via sense.
// - byte0 bit 4: no track zero after 80 steps, or relative seek past 0.
// - byte0 bit 2 current head, bits 1..0 current drive.
// - byte1 bit 7: access beyond last sector, or data command ends without count.
// - byte1 bit 5 set on CRC error in ID or data field.
// - byte1 bit 4 set on overrun or underrun from late service.
// - byte1 bit 2: sector not found, ID unreadable, or bad track sequence.
// - byte1 bit 1 set if write protect rises during write or format; the code sets it whenever the level is high then.
// - byte1 bit 0: no ID mark after two index pulses, or no data mark.
// - byte0 bit 3 and byte1 bits 6 and 3 always read 0.
// - two-bit interface mode field picks one of three register layouts.
// - rate bits reset to 250 Kbps by hardware reset only.
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH
`define FRS_CCR_IDX 12'h3F7
`define FRS_CCR_ADDR 12'hFDC
`define FRS_MODE_ADDR 12'h000
`define FRS_RES0_ADDR 12'h004
`define FRS_RES1_ADDR 12'h008
`define FRS_DATA_ADDR 12'h00C
`define FRS_PHASE_ADDR 12'h010
`define FRS_MODE_LSB 2
`define FRS_MODE_MSB 3
`define FRS_SKIP_WRITE_SHIFT_FLAG_BIT 2
`define FRS_RATE_RST 2'h2
`define FRS_RATE_500K 2'h0
`define FRS_RATE_1M 2'h3
`define FRS_SKIP_WRITE_SHIFT_FLAG_RST 1'b0
`define FRS_DENS_RST 1'b1
`define FRS_MODE_RST 2'h0
`define FRS_RECAL_STEPS 7'd80
`define FRS_IDX_LIMIT 2'd2
`endif

// ===== frs_pkg.sv
// types shared by the rate and result status block
`default_nettype none
package frs_pkg;
	typedef enum logic [1:0] {
		FRS_MODE_AT = 2'b00,
		FRS_MODE_PS2 = 2'b01,
		FRS_MODE_M30 = 2'b10
	} frs_mode_e;
	typedef enum logic [3:0] {
		FRS_CMD_NONE = 4'h0,
		FRS_CMD_READ = 4'h1,
		FRS_CMD_READ_DEL = 4'h2,
		FRS_CMD_WRITE = 4'h3,
		FRS_CMD_WRITE_DEL = 4'h4,
		FRS_CMD_FORMAT = 4'h5,
		FRS_CMD_READ_ID = 4'h6,
		FRS_CMD_READ_TRACK = 4'h7,
		FRS_CMD_RECAL = 4'h8,
		FRS_CMD_SEEK = 4'h9,
		FRS_CMD_REL_SEEK = 4'hA,
		FRS_CMD_SENSE_INT = 4'hB
	} frs_cmd_e;
	typedef enum logic [1:0] {
		FRS_PH_IDLE = 2'b00,
		FRS_PH_EXEC = 2'b01,
		FRS_PH_RESULT = 2'b10
	} frs_phase_e;
	typedef struct packed {
		logic [1:0] completionCode;
		logic positioningComplete;
		logic equipmentFault;
		logic head;
		logic [1:0] unitSelect;
		logic endOfTrack;
		logic crcFault;
		logic overrun;
		logic sectorMissing;
		logic writeProtectViolation;
		logic syncFieldAbsent;
	} frs_status_s;
	typedef struct packed {
		logic stepPulse;
		logic stepOutward;
		logic trackZeroIn;
		logic revolutionPulseInN;
		logic idMarkFound;
		logic dataMarkMissing;
		logic idCrcFault;
		logic dataCrcFault;
		logic serviceLate;
		logic sectorNotFound;
		logic idReadFail;
		logic badSequence;
		logic sectorBeyondEnd;
		logic terminalCountIn;
		logic writeProtectIn;
	} frs_media_s;
	function automatic logic frs_is_position(input frs_cmd_e c);
		return c == FRS_CMD_RECAL || c == FRS_CMD_SEEK || c == FRS_CMD_REL_SEEK;
	endfunction : frs_is_position
	function automatic logic frs_is_write(input frs_cmd_e c);
		return c == FRS_CMD_WRITE || c == FRS_CMD_WRITE_DEL || c == FRS_CMD_FORMAT;
	endfunction : frs_is_write
	function automatic logic frs_is_data(input frs_cmd_e c);
		return c == FRS_CMD_READ || c == FRS_CMD_READ_DEL ||
			c == FRS_CMD_WRITE || c == FRS_CMD_WRITE_DEL;
	endfunction : frs_is_data
endpackage : frs_pkg
`default_nettype wire

// ===== frs_status_pack.sv
// packs latched status fields into result bytes 0 and 1
`default_nettype none
module frs_status_pack
	import frs_pkg::*;
(
	// latched fields
	input wire frs_status_s status,
	// result bytes
	output logic [7:0] byte0,
	output logic [7:0] byte1
);
	always_comb begin
		byte0 = {status.completionCode, status.positioningComplete,
			status.equipmentFault, 1'b0, status.head, status.unitSelect};
		byte1 = {status.endOfTrack, 1'b0, status.crcFault, status.overrun,
			1'b0, status.sectorMissing, status.writeProtectViolation,
			status.syncFieldAbsent};
	end
endmodule : frs_status_pack
`default_nettype wire

// ===== frs_top_asserts.sv
// concurrent checks on the rate select, density pin and result phase ports
`include "frs_cfg.svh"
`default_nettype none
module frs_top_asserts
	import frs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// engine and pins
	input wire logic swReset,
	input wire logic execEnd,
	input wire logic [1:0] ratePick,
	input wire logic densityOut,
	input wire logic resultPhase
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire logic acc = psel && penable;
	wire logic ccrWr = acc && pwrite && paddr == `FRS_CCR_ADDR;
	wire logic dataRd = acc && !pwrite && paddr == `FRS_DATA_ADDR;
	wire logic rd0 = acc && !pwrite && paddr == `FRS_RES0_ADDR;
	wire logic rd1 = acc && !pwrite && paddr == `FRS_RES1_ADDR;
	logic oneRead;
	// one data read already taken in this result phase
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			oneRead <= 1'b0;
		end else if (!resultPhase || swReset) begin
			oneRead <= 1'b0;
		end else if (dataRd) begin
			oneRead <= !oneRead;
		end
	end
	sequence twoReads;
		resultPhase && dataRd && oneRead;
	endsequence
	rate_write_a: assert property (ccrWr |=> ratePick == $past(pwdata[1:0]))
		else $error("rate select not loaded");
	rate_hold_a: assert property (!ccrWr |=> $stable(ratePick))
		else $error("rate select changed without write");
	dens_hold_a: assert property ($changed(densityOut) |-> $past(ccrWr))
		else $error("density pin changed without write");
	sw_clear_a: assert property (swReset |=> !resultPhase)
		else $error("result phase survived core reset");
	phase_rise_a: assert property ($rose(resultPhase) |-> $past(execEnd))
		else $error("result phase without execution end");
	phase_hold_a: assert property (resultPhase && !swReset && !dataRd |=> resultPhase)
		else $error("result phase dropped early");
	read_end_a: assert property (twoReads |=> !resultPhase)
		else $error("result phase not ended by second read");
	spare_zero_a: assert property (rd0 |-> !prdata[3])
		else $error("spare bit of byte0 set");
	spare_one_a: assert property (rd1 |-> !prdata[6] && !prdata[3])
		else $error("spare bits of byte1 set");
endmodule : frs_top_asserts
bind frs_top frs_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.swReset(swReset), .execEnd(execEnd), .ratePick(ratePick), .densityOut(densityOut),
	.resultPhase(resultPhase));
`default_nettype wire

// ===== frs_apb_host.sv
// apb host model issuing register transfers to the block
`default_nettype none
module frs_apb_host (
	// clock
	input wire logic mclk,
	// apb master
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h0,
	output logic [31:0] pwdata = 32'h0,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~wd;
		@(posedge mclk);
	endtask : xfer
endmodule : frs_apb_host
`default_nettype wire

// ===== tb_floppy_rate_ctrl_and_result_status.sv
// self-checking bench for the rate select and result status block
`include "frs_cfg.svh"
`default_nettype none
module tb_floppy_rate_ctrl_and_result_status
	import frs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam frs_media_s IDLE = 15'h0800;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, err, densityOut, resultPhase;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic swReset = 1'b0, execStart = 1'b0, execEnd = 1'b0, headIn = 1'b0;
	logic [1:0] completionCode = 2'h0, unitSelect = 2'h0, ratePick;
	frs_cmd_e cmdKind = FRS_CMD_NONE;
	frs_media_s media = IDLE, lv = IDLE;
	int badCount = 0, checks = 0, cyc = 0;
	initial forever #2 mclk = ~mclk;
	frs_top u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.swReset(swReset), .execStart(execStart), .cmdKind(cmdKind), .execEnd(execEnd),
		.completionCode(completionCode), .headIn(headIn), .unitSelect(unitSelect),
		.media(media), .ratePick(ratePick), .densityOut(densityOut), .resultPhase(resultPhase));
	frs_apb_host u_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			badCount++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rdv, err);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		u_host.xfer(1'b0, a, 32'h0, rdv, err);
	endtask : rd
	task automatic pulse(input frs_media_s m);
		media <= lv ^ m;
		@(posedge mclk);
		media <= lv;
		@(posedge mclk);
	endtask : pulse
	task automatic run(input frs_cmd_e c);
		cmdKind <= c;
		execStart <= 1'b1;
		@(posedge mclk);
		execStart <= 1'b0;
		@(posedge mclk);
	endtask : run
	task automatic stop(input logic [1:0] code, input logic h, input logic [1:0] u);
		completionCode <= code;
		headIn <= h;
		unitSelect <= u;
		execEnd <= 1'b1;
		@(posedge mclk);
		execEnd <= 1'b0;
		@(posedge mclk);
	endtask : stop
	task automatic results(input logic [7:0] b0, input logic [7:0] b1);
		@(posedge mclk);
		chk(resultPhase, 1);
		rd(`FRS_RES1_ADDR);
		chk(rdv, b1);
		rd(`FRS_DATA_ADDR);
		chk(rdv, b0);
		rd(`FRS_DATA_ADDR);
		chk(rdv, b1);
		chk(resultPhase, 0);
	endtask : results
	task automatic t_reset();
		chk(ratePick, 2);
		chk(densityOut, 1);
		rd(12'h020);
		chk(err, 1);
		chk(rdv, 0);
	endtask : t_reset
	task automatic t_rates();
		logic hr;
		for (int m = 0; m < 3; m++) begin
			wr(`FRS_MODE_ADDR, m << 2);
			rd(`FRS_MODE_ADDR);
			chk(rdv, m << 2);
			for (int r = 0; r < 4; r++) begin
				hr = (r == 0 || r == 3);
				wr(`FRS_CCR_ADDR, (m == 2 && r[0]) ? r + 4 : r);
				chk(ratePick, r);
				chk(densityOut, (m == 0) ? hr : !hr);
				rd(`FRS_CCR_ADDR);
				chk(rdv, (m == 0) ? 0 : (m == 1) ? 32'h78 | r << 1 | !hr : r[0] * 4 + r);
			end
		end
		swReset <= 1'b1;
		@(posedge mclk);
		swReset <= 1'b0;
		@(posedge mclk);
		chk(ratePick, 3);
		chk(densityOut, 0);
		rd(`FRS_CCR_ADDR);
		chk(rdv, 7);
		wr(`FRS_MODE_ADDR, 0);
	endtask : t_rates
	task automatic t_read();
		frs_media_s m;
		m = '0;
		m.idCrcFault = 1'b1;
		m.serviceLate = 1'b1;
		m.sectorNotFound = 1'b1;
		run(FRS_CMD_READ);
		pulse(m);
		stop(2'h1, 1'b1, 2'h3);
		results(8'h47, 8'hB4);
	endtask : t_read
	task automatic t_write();
		frs_media_s m;
		m = '0;
		m.dataMarkMissing = 1'b1;
		run(FRS_CMD_WRITE);
		lv = 15'h0803;
		media <= lv;
		@(posedge mclk);
		pulse(m);
		stop(2'h2, 1'b0, 2'h0);
		lv = IDLE;
		media <= IDLE;
		results(8'h80, 8'h03);
	endtask : t_write
	task automatic t_readid();
		frs_media_s m;
		m = '0;
		m.revolutionPulseInN = 1'b1;
		m.idReadFail = 1'b1;
		run(FRS_CMD_READ_ID);
		pulse(m);
		pulse(m);
		stop(2'h3, 1'b1, 2'h1);
		results(8'hC5, 8'h05);
	endtask : t_readid
	task automatic t_pos(input frs_cmd_e c, input frs_media_s l, input int n,
		input logic [7:0] b0);
		frs_media_s s;
		s = '0;
		s.stepPulse = 1'b1;
		lv = l;
		media <= l;
		run(c);
		repeat (n) pulse(s);
		stop(2'h0, 1'b0, 2'h1);
		chk(resultPhase, 0);
		lv = IDLE;
		media <= IDLE;
		run(FRS_CMD_SENSE_INT);
		stop(2'h0, 1'b0, 2'h1);
		results(b0, 8'h00);
	endtask : t_pos
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_rates();
		t_read();
		t_write();
		t_readid();
		t_pos(FRS_CMD_RECAL, IDLE, 80, 8'h31);
		t_pos(FRS_CMD_RECAL, IDLE, 79, 8'h21);
		t_pos(FRS_CMD_REL_SEEK, 15'h3800, 1, 8'h31);
		t_pos(FRS_CMD_SEEK, IDLE, 3, 8'h21);
		final_report();
	end
endmodule : tb_floppy_rate_ctrl_and_result_status
`default_nettype wire
